/* File: bench/alert_sva.sv */
`timescale 1ns/100ps
module alert_sva
    import alert_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // inputs
    input wire logic run_enable,
    input wire logic scheme_select,
    input wire logic misc_event,
    input wire logic spi_cs_n,
    input wire logic spi_sclk_rise,
    input wire logic flag_read_cmd,
    // outputs
    input wire logic alert_out,
    input wire logic alert_oe_n,
    input wire logic [24:0] flags_latched,
    input wire logic [24:0] flags_live,
    input wire logic scheme_active
);
    // ------------------------------------------------------------
    // frame tracking and low-phase counter
    // ------------------------------------------------------------
    logic rd_seen_r;
    logic sclk_seen_r;
    logic [15:0] low_cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // read seen in the current or last frame
    always_ff @(posedge clk) begin
        if (srst || (spi_sclk_rise && !sclk_seen_r)) rd_seen_r <= 1'h0;
        else if (!spi_cs_n && flag_read_cmd) rd_seen_r <= 1'h1;
    end
    // first serial clock of a frame
    always_ff @(posedge clk) begin
        if (srst || spi_cs_n) sclk_seen_r <= 1'h0;
        else if (spi_sclk_rise) sclk_seen_r <= 1'h1;
    end
    // consecutive cycles with the pin pulled low
    always_ff @(posedge clk) begin
        if (srst || alert_oe_n) low_cnt_r <= 16'h0;
        else low_cnt_r <= low_cnt_r + 16'h1;
    end
    // release, then pin stays released for eight cycles from two cycles on
    sequence released_s;
        ##2 alert_oe_n [*8];
    endsequence
    AST_OD_DATA: assert property (alert_out == 1'h0) else $error("alert data not low");
    AST_SCHEME_TAKE: assert property (!run_enable |=> scheme_active == $past(scheme_select)) else $error("scheme not taken");
    AST_SCHEME_HOLD: assert property (run_enable && $past(run_enable) |-> $stable(scheme_active)) else $error("scheme changed while running");
    AST_RESET_VAL: assert property ($fell(srst) |-> !scheme_active && flags_live == 25'h0) else $error("bad reset state");
    AST_READ_REL: assert property ($rose(spi_cs_n) && rd_seen_r |-> released_s) else $error("pin not released");
    AST_STATIC_LOW: assert property (run_enable && !scheme_active && !alert_oe_n && !rd_seen_r |=> !alert_oe_n) else $error("static low lost");
    AST_IDLE_REL: assert property (flags_live == 25'h0 |-> alert_oe_n) else $error("pin low with no event");
    AST_DYN_LOW: assert property (scheme_active && $rose(alert_oe_n) && !rd_seen_r |-> low_cnt_r == ALERT_LOW_CYCLES) else $error("low phase length");
    AST_LATCH: assert property (!spi_cs_n && spi_sclk_rise && !sclk_seen_r |=> flags_latched == $past(flags_live)) else $error("flag snapshot");
    AST_MISC_FLAG: assert property (misc_event |=> flags_live[24]) else $error("event flag missing");
endmodule : alert_sva

/* File: bench/host_model.sv */
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clk,
    // serial frame toward the device
    output logic spi_cs_n,
    output logic spi_sclk_rise,
    output logic flag_read_cmd,
    output logic host_regulator_hold
);
    // idle: deselected, serial clock still
    initial begin
        spi_cs_n = 1'h1;
        spi_sclk_rise = 1'h0;
        flag_read_cmd = 1'h0;
        host_regulator_hold = 1'h0;
    end
    // one frame, two serial clocks; rd reads the flag register
    task automatic frame(input logic rd);
        @(posedge clk) #1 spi_cs_n = 1'h0;
        @(posedge clk) #1 spi_sclk_rise = 1'h1;
        host_regulator_hold = host_regulator_hold | rd;
        @(posedge clk) #1 spi_sclk_rise = 1'h0;
        flag_read_cmd = rd;
        @(posedge clk) #1 flag_read_cmd = 1'h0;
        spi_sclk_rise = 1'h1;
        @(posedge clk) #1 spi_sclk_rise = 1'h0;
        @(posedge clk) #1 spi_cs_n = 1'h1;
        repeat (3) @(posedge clk);
        #1;
    endtask : frame
endmodule : host_model

/* File: bench/switch_monitor_interrupt_logic_test.sv */
`timescale 1ns/100ps
module switch_monitor_interrupt_logic_test
    import alert_pkg::*;
;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic run_enable = 1'h0;
    logic scheme_select = 1'h0;
    logic [1:0] debounce_depth_field = 2'h0;
    logic [23:0] edge_enable_reg_a = 24'h0;
    logic [23:0] edge_enable_reg_b = 24'h0;
    logic sample_valid = 1'h0;
    logic [23:0] sample_above = 24'h0;
    logic misc_event = 1'h0;
    logic spi_cs_n, spi_sclk_rise, flag_read_cmd, hold, alert_out, alert_oe_n, scheme_active, holdoff_active;
    logic [24:0] flags_latched, flags_live;
    logic [23:0] switch_status;
    int error_cnt = 0;
    int n_checks = 0;
    // clock and blocks
    always #5 clk = ~clk;
    host_model host_u (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk_rise(spi_sclk_rise),
        .flag_read_cmd(flag_read_cmd), .host_regulator_hold(hold));
    switch_monitor_interrupt_logic dut_u (.clk(clk), .srst(srst), .run_enable(run_enable),
        .scheme_select(scheme_select), .debounce_depth_field(debounce_depth_field),
        .edge_enable_reg_a(edge_enable_reg_a), .edge_enable_reg_b(edge_enable_reg_b),
        .sample_valid(sample_valid), .sample_above(sample_above), .misc_event(misc_event),
        .spi_cs_n(spi_cs_n), .spi_sclk_rise(spi_sclk_rise), .flag_read_cmd(flag_read_cmd),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n), .flags_latched(flags_latched),
        .flags_live(flags_live), .switch_status(switch_status), .scheme_active(scheme_active),
        .holdoff_active(holdoff_active));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic sample(input logic [23:0] v);
        sample_valid = 1'h1;
        sample_above = v;
        tick(1);
        sample_valid = 1'h0;
        tick(1);
    endtask : sample
    task automatic misc();
        misc_event = 1'h1;
        tick(1);
        misc_event = 1'h0;
        tick(1);
    endtask : misc
    task automatic wait_oe(input logic val, output int n);
        n = 0;
        while (alert_oe_n !== val && n < 6000) begin
            tick(1);
            n++;
        end
    endtask : wait_oe
    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_static();
        int n;
        cmp({flags_live[23:0], scheme_active}, 25'h0);
        edge_enable_reg_a = 24'h1;
        edge_enable_reg_b = 24'h2;
        tick(1);
        run_enable = 1'h1;
        sample(24'h0);
        sample(24'h3);
        cmp({flags_live[23:0], alert_oe_n}, 25'h2);
        sample(24'h0);
        cmp(flags_live, 25'h3);
        host_u.frame(1'h1);
        cmp(flags_latched, 25'h3);
        cmp({flags_live[23:0], alert_oe_n}, 25'h1);
        cmp(25'(holdoff_active), 25'h0);
        cmp(25'(hold), 25'h1);
        misc();
        cmp(flags_live, 25'h1000000);
        cmp(25'(holdoff_active), 25'h1);
        tick(1800);
        wait_oe(1'h0, n);
        cmp(25'(n > 0 && n < 400), 25'h1);
        host_u.frame(1'h1);
        misc();
        host_u.frame(1'h1);
        cmp(flags_live, 25'h0);
        tick(2400);
        cmp(25'(alert_oe_n), 25'h1);
        cmp(25'(holdoff_active), 25'h0);
    endtask : t_static
    task automatic t_depth();
        for (int d = 1; d < 4; d++) begin
            run_enable = 1'h0;
            debounce_depth_field = 2'(d);
            tick(1);
            run_enable = 1'h1;
            sample(24'h0);
            sample(24'h1);
            sample(24'h0);
            repeat (d) sample(24'h1);
            cmp(flags_live, 25'h0);
            sample(24'h1);
            cmp(flags_live, 25'h1);
            host_u.frame(1'h1);
        end
    endtask : t_depth
    // both edges on input 23, rising only on 12, falling only on 11
    task automatic t_both();
        run_enable = 1'h0;
        debounce_depth_field = 2'h0;
        edge_enable_reg_a = 24'h801000;
        edge_enable_reg_b = 24'h800800;
        tick(1);
        run_enable = 1'h1;
        sample(24'h000800);
        cmp(25'(switch_status), 25'h800);
        sample(24'h801000);
        cmp(flags_live, 25'h801800);
        cmp(25'(switch_status), 25'h801000);
        host_u.frame(1'h1);
        sample(24'h000800);
        cmp(flags_live, 25'h800000);
        host_u.frame(1'h1);
    endtask : t_both
    task automatic t_dynamic();
        int n;
        tick(2100);
        scheme_select = 1'h1;
        tick(2);
        cmp(25'(scheme_active), 25'h0);
        run_enable = 1'h0;
        tick(2);
        cmp(25'(scheme_active), 25'h1);
        run_enable = 1'h1;
        host_u.frame(1'h0);
        misc();
        wait_oe(1'h1, n);
        wait_oe(1'h0, n);
        cmp(25'(n), 25'(ALERT_HIGH_CYCLES));
        wait_oe(1'h1, n);
        cmp(25'(n), 25'(ALERT_LOW_CYCLES));
        host_u.frame(1'h1);
        cmp(flags_live, 25'h0);
        tick(11000);
        cmp(25'(alert_oe_n), 25'h1);
        misc();
        tick(100);
        host_u.frame(1'h1);
        cmp({flags_live[23:0], alert_oe_n}, 25'h1);
        tick(6000);
        cmp(25'(alert_oe_n), 25'h1);
    endtask : t_dynamic
    // main sequence and watchdog
    initial begin
        tick(2);
        srst = 1'h0;
        tick(1);
        t_static();
        t_depth();
        t_both();
        t_dynamic();
        end_of_test();
    end
    initial begin
        #1ms;
        error_cnt++;
        end_of_test();
    end
endmodule : switch_monitor_interrupt_logic_test
bind switch_monitor_interrupt_logic alert_sva chk_u (.clk(clk), .srst(srst), .run_enable(run_enable),
    .scheme_select(scheme_select), .misc_event(misc_event), .spi_cs_n(spi_cs_n),
    .spi_sclk_rise(spi_sclk_rise), .flag_read_cmd(flag_read_cmd), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .flags_latched(flags_latched), .flags_live(flags_live),
    .scheme_active(scheme_active));

/* File: hdl/alert_pkg.sv */
package alert_pkg;

    // --------------------------------------------------------------
    // sizes
    // --------------------------------------------------------------
    localparam int NUM_INPUTS = 24;
    localparam int CLK_MHZ = 100;

    // --------------------------------------------------------------
    // alert timing, microseconds and derived cycle counts
    // --------------------------------------------------------------
    localparam int ALERT_LOW_TIME_US = 50;
    localparam int ALERT_HIGH_TIME_US = 50;
    localparam int HOLDOFF_TIME_US = 20;
    localparam int ALERT_LOW_CYCLES = ALERT_LOW_TIME_US * CLK_MHZ;
    localparam int ALERT_HIGH_CYCLES = ALERT_HIGH_TIME_US * CLK_MHZ;
    localparam int HOLDOFF_CYCLES = HOLDOFF_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 16;

    // --------------------------------------------------------------
    // setup fields and reset values
    // --------------------------------------------------------------
    localparam logic SCHEME_STATIC = 1'h0;
    localparam logic SCHEME_DYNAMIC = 1'h1;
    localparam logic SCHEME_RESET = 1'h0;
    localparam logic [1:0] DEPTH_ANY = 2'h0;
    localparam logic [1:0] DEPTH_RESET = 2'h0;
    localparam logic [2:0] STABLE_MAX = 3'h4;
    localparam logic [23:0] EDGE_EN_RESET = 24'h000000;

    // alert pin sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOW = 4'h2,
        ST_HIGH = 4'h4,
        ST_HOLD = 4'h8
    } alert_state_type;

endpackage : alert_pkg

/* File: hdl/switch_monitor_interrupt_logic.sv */
// Function
// - setup bit picks static or dynamic alert
// - static: low until flag-read chip-select rise
// - flags latched first sclk, cleared on read
// - dynamic: toggle low/high until flags read
// - read while low releases pin, clears flags
// - read while high clears, no further low
// - scheme resets static, changes only when stopped
// - flag read starts hold-off interval
// - events in hold-off flag now, alert later
// - second read in hold-off cancels later alert
// - no pending event leaves pin undriven
// - per-input edge enables via two registers
// - rising, falling or both trigger conditions
// - edge enables reset to disabled
// - debounce any crossing or 2/3/4 stable
// - depth 11 needs four stable cycles
// - reference status stored after first cycle
// - stopping run clears debounce counter
// - depth resets to any crossing
// - alert is active-low open-drain
`timescale 1ns/100ps
module switch_monitor_interrupt_logic
    import alert_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration
    input wire logic run_enable,
    input wire logic scheme_select,
    input wire logic [1:0] debounce_depth_field,
    input wire logic [23:0] edge_enable_reg_a,
    input wire logic [23:0] edge_enable_reg_b,
    // detection results
    input wire logic sample_valid,
    input wire logic [23:0] sample_above,
    input wire logic misc_event,
    // serial port events
    input wire logic spi_cs_n,
    input wire logic spi_sclk_rise,
    input wire logic flag_read_cmd,
    // alert pin, open drain
    output logic alert_out,
    output logic alert_oe_n,
    // status
    output logic [24:0] flags_latched,
    output logic [24:0] flags_live,
    output logic [23:0] switch_status,
    output logic scheme_active,
    output logic holdoff_active
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    logic scheme_r;
    logic [1:0] depth_r;
    logic [23:0] en_a_r;
    logic [23:0] en_b_r;
    logic [23:0] ref_r;
    logic ref_valid_r;
    logic [2:0] stable_r [NUM_INPUTS];
    logic [23:0] change_evt;
    logic [24:0] flags_r;
    logic [24:0] latch_r;
    logic cs_d_r;
    logic first_edge_r;
    logic read_seen_r;
    logic cs_rise;
    logic read_now;
    logic any_event;
    logic pending;
    alert_state_type state_r;
    alert_state_type state_nxt;
    logic [TIMER_W-1:0] timer_r;
    logic timer_done;
    logic rearm_r;

    // stable cycles needed for a depth code
    function automatic logic [2:0] need_count(input logic [1:0] d);
        return (d == DEPTH_ANY) ? 3'h1 : 3'(d) + 3'h1;
    endfunction : need_count

    // --------------------------------------------------------------
    // configuration capture
    // --------------------------------------------------------------
    // settings move only while run is stopped
    always_ff @(posedge clk) begin
        if (srst) begin
            scheme_r <= SCHEME_RESET;
            depth_r <= DEPTH_RESET;
            en_a_r <= EDGE_EN_RESET;
            en_b_r <= EDGE_EN_RESET;
        end else if (!run_enable) begin
            scheme_r <= scheme_select;
            depth_r <= debounce_depth_field;
            en_a_r <= edge_enable_reg_a;
            en_b_r <= edge_enable_reg_b;
        end
    end

    // --------------------------------------------------------------
    // debounce and edge detection
    // --------------------------------------------------------------
    // reference status taken on first detection cycle
    always_ff @(posedge clk) begin
        if (srst || !run_enable) begin
            ref_valid_r <= 1'b0;
            ref_r <= '0;
        end else if (sample_valid) begin
            ref_valid_r <= 1'b1;
            if (!ref_valid_r) begin
                ref_r <= sample_above;
            end else begin
                for (int i = 0; i < NUM_INPUTS; i++) begin
                    if (change_evt[i] || (sample_above[i] != ref_r[i] &&
                        stable_r[i] + 3'h1 >= need_count(depth_r))) begin
                        ref_r[i] <= sample_above[i];
                    end
                end
            end
        end
    end

    // per-input count of consecutive differing samples
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (srst || !run_enable) begin
                stable_r[i] <= 3'h0;
            end else if (sample_valid && ref_valid_r) begin
                if (sample_above[i] == ref_r[i]) begin
                    stable_r[i] <= 3'h0;
                end else if (stable_r[i] + 3'h1 >= need_count(depth_r)) begin
                    stable_r[i] <= 3'h0;
                end else if (stable_r[i] < STABLE_MAX) begin
                    stable_r[i] <= stable_r[i] + 3'h1;
                end
            end
        end
    end

    // qualified crossing, gated by rising/falling enables
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            change_evt[i] = run_enable && sample_valid && ref_valid_r &&
                sample_above[i] != ref_r[i] &&
                (stable_r[i] + 3'h1 >= need_count(depth_r)) &&
                ((sample_above[i] && en_a_r[i]) || (!sample_above[i] && en_b_r[i]));
        end
    end

    // --------------------------------------------------------------
    // serial transaction tracking
    // --------------------------------------------------------------
    assign cs_rise = spi_cs_n && !cs_d_r;
    assign read_now = read_seen_r && cs_rise;
    assign any_event = (|change_evt) || misc_event;

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_d_r <= 1'b1;
            first_edge_r <= 1'b0;
            read_seen_r <= 1'b0;
        end else begin
            cs_d_r <= spi_cs_n;
            if (spi_cs_n) begin
                first_edge_r <= 1'b0;
                read_seen_r <= 1'b0;
            end else begin
                if (spi_sclk_rise) begin
                    first_edge_r <= 1'b1;
                end
                if (flag_read_cmd) begin
                    read_seen_r <= 1'b1;
                end
            end
        end
    end

    // snapshot on first sclk rise of each frame
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_r <= '0;
        end else if (!spi_cs_n && spi_sclk_rise && !first_edge_r) begin
            latch_r <= flags_r;
        end
    end

    // event flags: new events win over the read clear
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= '0;
        end else begin
            flags_r <= (read_now ? 25'h0000000 : flags_r) | {misc_event, change_evt};
        end
    end
    assign pending = |flags_r;

    // --------------------------------------------------------------
    // alert pin sequencer
    // --------------------------------------------------------------
    assign timer_done = (timer_r == '0);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (any_event) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (read_now) begin
                    state_nxt = ST_HOLD;
                end else if (scheme_r == SCHEME_DYNAMIC && timer_done) begin
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (read_now) begin
                    state_nxt = ST_HOLD;
                end else if (timer_done) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_HOLD: begin
                if (timer_done) begin
                    // flags still set, e.g. an event in the read cycle, re-assert too
                    state_nxt = (rearm_r || pending || any_event) ? ST_LOW : ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // one down-counter serves all three durations
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_r <= '0;
        end else if (state_nxt != state_r) begin
            case (state_nxt)
                ST_LOW: timer_r <= TIMER_W'(ALERT_LOW_CYCLES - 1);
                ST_HIGH: timer_r <= TIMER_W'(ALERT_HIGH_CYCLES - 1);
                ST_HOLD: timer_r <= TIMER_W'(HOLDOFF_CYCLES - 1);
                default: timer_r <= '0;
            endcase
        end else if (!timer_done) begin
            timer_r <= timer_r - 1'b1;
        end
    end

    // event seen during hold-off, dropped by a second read
    always_ff @(posedge clk) begin
        if (srst || state_r != ST_HOLD) begin
            rearm_r <= 1'b0;
        end else if (any_event) begin
            rearm_r <= 1'b1;
        end else if (read_now) begin
            rearm_r <= 1'b0;
        end
    end

    // pin driven low only in the low phase, else released
    always_ff @(posedge clk) begin
        if (srst) begin
            alert_oe_n <= 1'b1;
        end else begin
            alert_oe_n <= (state_nxt != ST_LOW);
        end
    end
    assign alert_out = 1'b0;

    // --------------------------------------------------------------
    // status outputs
    // --------------------------------------------------------------
    assign flags_latched = latch_r;
    assign flags_live = flags_r;
    assign switch_status = ref_r;
    assign scheme_active = scheme_r;
    assign holdoff_active = (state_r == ST_HOLD) && pending;

endmodule : switch_monitor_interrupt_logic
